// ### rtl/cbs_core_regs.sv
// core bank select, accumulator, table and status register logic
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cbs_core_regs
  import cbs_pkg::*;
#(
  parameter logic [1:0] VARIANT = CBS_VAR_LARGE
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // software register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // alu operation from the instruction decoder
  input wire logic alu_go_i,
  input wire logic [2:0] alu_op_i,
  input wire logic [7:0] alu_operand_i,
  input wire logic alu_to_acc_i,
  output logic [7:0] alu_result_o,
  output logic alu_result_vld_o,
  // system events
  input wire logic wdt_timeout_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic halt_instr_i,
  input wire logic wdt_reset_in_pd_i,
  input wire logic soft_reset_i,
  // table read and program memory
  input wire logic tbl_read_i,
  output logic [15:0] prog_addr_o,
  output logic prog_rd_o,
  input wire logic [15:0] prog_data_i,
  output logic [7:0] tbl_low_o,
  output logic tbl_low_vld_o,
  // data memory addressing
  input wire logic dm_indirect_i,
  input wire logic [7:0] dm_addr_i,
  output logic [10:0] dm_addr_o,
  output logic dm_bank_bad_o,
  // program counter and stall
  input wire logic pc_adv_i,
  output logic [13:0] prog_counter_o,
  output logic stall_o,
  // interrupt and flags
  output logic irq_o,
  output logic [7:0] status_o
);
  logic [7:0] bank_select;
  logic [7:0] accumulator;
  logic [7:0] table_ptr_low;
  logic [7:0] table_ptr_high;
  logic [7:0] table_data_high;
  logic [7:0] status_flags;
  logic [13:0] prog_counter;
  logic [2:0] irq_st;
  logic [2:0] irq_en;
  cbs_state_t state;
  cbs_state_t next_state;

  // implemented bank register bits of one variant
  function automatic logic [7:0] bank_bits(input logic [1:0] v);
    if (v == CBS_VAR_SMALL)
      return CBS_BANK_MASK_SMALL;
    else if (v == CBS_VAR_MID)
      return CBS_BANK_MASK_MID;
    else
      return CBS_BANK_MASK_LARGE;
  endfunction

  // implemented bits of the bank register depend on the variant
  wire [7:0] bank_mask = bank_bits(VARIANT);
  wire [2:0] data_bank = bank_select[2:0];
  wire data_bank_sel_b0 = bank_select[0];
  wire prog_bank_sel = (VARIANT == CBS_VAR_LARGE) &
    bank_select[CBS_PBANK_BIT];

  // register decode
  wire hit_bank = (addr_i == CBS_ADDR_BANK);
  wire hit_acc = (addr_i == CBS_ADDR_ACC);
  wire hit_pcl = (addr_i == CBS_ADDR_PCL);
  wire hit_table_ptr_low = (addr_i == CBS_ADDR_TABLE_PTR_LOW);
  wire hit_table_ptr_high = (addr_i == CBS_ADDR_TABLE_PTR_HIGH);
  wire hit_table_data_high = (addr_i == CBS_ADDR_TABLE_DATA_HIGH);
  wire hit_stat = (addr_i == CBS_ADDR_STATUS);
  wire hit_ist = (addr_i == CBS_ADDR_IRQ_ST);
  wire hit_ien = (addr_i == CBS_ADDR_IRQ_EN);
  wire hit_iclr = (addr_i == CBS_ADDR_IRQ_CLR);

  // alu: results land in the accumulator only with alu_to_acc_i, no reg-to-reg path;
  // narrow nibble and 7-bit adders give the carries into bit 4 and
  // bit 7 directly, at the cost of a few duplicated adder cells
  wire [4:0] lo_add = {1'b0, accumulator[3:0]} + {1'b0, alu_operand_i[3:0]};
  wire [4:0] lo_sub = {1'b0, accumulator[3:0]} + {1'b0, ~alu_operand_i[3:0]}
    + 5'h01;
  wire [7:0] add7 = {1'b0, accumulator[6:0]} + {1'b0, alu_operand_i[6:0]};
  wire [7:0] sub7 = {1'b0, accumulator[6:0]} + {1'b0, ~alu_operand_i[6:0]}
    + 8'h01;
  wire [8:0] add9 = {1'b0, accumulator} + {1'b0, alu_operand_i};
  wire [8:0] sub9 = {1'b0, accumulator} + {1'b0, ~alu_operand_i} + 9'h001;
  logic [7:0] res;
  logic c_n;
  logic ac_n;
  logic ov_n;
  logic arith;
  logic flag_c_only;
  always_comb
  begin
    res = 8'h00;
    c_n = status_flags[CBS_C_BIT];
    ac_n = status_flags[CBS_AC_BIT];
    ov_n = status_flags[CBS_OV_BIT];
    arith = 1'b0;
    flag_c_only = 1'b0;
    case (alu_op_i)
      CBS_OP_ADD:
      begin
        res = add9[7:0];
        c_n = add9[8];
        ac_n = lo_add[4];
        ov_n = add7[7] ^ add9[8];
        arith = 1'b1;
      end
      CBS_OP_SUB:
      begin
        res = sub9[7:0];
        c_n = sub9[8];
        ac_n = lo_sub[4];
        ov_n = sub7[7] ^ sub9[8];
        arith = 1'b1;
      end
      CBS_OP_AND: res = accumulator & alu_operand_i;
      CBS_OP_OR: res = accumulator | alu_operand_i;
      CBS_OP_XOR: res = accumulator ^ alu_operand_i;
      CBS_OP_RLC:
      begin
        res = {alu_operand_i[6:0], status_flags[CBS_C_BIT]};
        c_n = alu_operand_i[7];
        flag_c_only = 1'b1;
      end
      CBS_OP_RRC:
      begin
        res = {status_flags[CBS_C_BIT], alu_operand_i[7:1]};
        c_n = alu_operand_i[0];
        flag_c_only = 1'b1;
      end
      default: res = alu_operand_i;
    endcase
  end
  // alu ops are refused while the sequencer is in a dummy or table cycle
  wire alu_fire = alu_go_i & (state == CBS_RUN);
  wire z_n = (res == 8'h00);

  // next status: writes mask off timeout and power-down bits
  // a timeout beside clear or halt wins so that it is never lost
  logic [7:0] next_status;
  always_comb
  begin
    next_status = status_flags;
    if (wr_i && hit_stat)
      next_status = (status_flags & ~CBS_STATUS_WMASK) |
        (wdata_i & CBS_STATUS_WMASK);
    if (alu_fire)
    begin
      next_status[CBS_C_BIT] = c_n;
      if (!flag_c_only)
        next_status[CBS_Z_BIT] = z_n;
      if (arith)
      begin
        next_status[CBS_AC_BIT] = ac_n;
        next_status[CBS_OV_BIT] = ov_n;
      end
    end
    // system flags: only these events move them
    if (watchdog_clear_instr_i)
    begin
      next_status[CBS_PDF_BIT] = 1'b0;
      next_status[CBS_TO_BIT] = 1'b0;
    end
    else if (halt_instr_i)
    begin
      next_status[CBS_PDF_BIT] = 1'b1;
      next_status[CBS_TO_BIT] = 1'b0;
    end
    if (wdt_timeout_i)
      next_status[CBS_TO_BIT] = 1'b1;
  end

  // dummy cycle after a counter low write, and table fetch cycle
  wire pcl_wr = wr_i & hit_pcl;
  always_comb
  begin
    next_state = state;
    case (state)
      CBS_RUN:
        if (pcl_wr)
          next_state = CBS_DUMMY;
        else if (tbl_read_i)
          next_state = CBS_TBL;
      CBS_DUMMY: next_state = CBS_RUN;
      CBS_TBL: next_state = CBS_RUN;
      default: next_state = CBS_RUN;
    endcase
  end

  // bad bank code on the largest variant
  wire bank_bad = (VARIANT == CBS_VAR_LARGE) &
    (data_bank > CBS_LAST_BANK);
  // direct access and special registers ignore the bank
  wire to_bank0 = ~dm_indirect_i | (dm_addr_i < CBS_SFR_TOP);
  wire [2:0] eff_bank = to_bank0 ? 3'h0 :
    (VARIANT == CBS_VAR_SMALL) ? {2'b00, data_bank_sel_b0} :
    (VARIANT == CBS_VAR_MID) ? {1'b0, data_bank[1:0]} : data_bank;
  wire dm_bad_n = ~to_bank0 & bank_bad;

  // events latch into sticky status; clear write loses to a new event
  wire [2:0] irq_ev = {dm_bad_n, halt_instr_i, wdt_timeout_i};
  wire [2:0] irq_clr = (wr_i & hit_iclr) ? wdata_i[2:0] : 3'h0;
  wire [2:0] next_irq_st = (irq_st & ~irq_clr) | irq_ev;

  // read mux: address decode as a priority chain, unknown reads give 0
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_bank)
      rd_mux = bank_select & bank_mask;
    else if (hit_acc)
      rd_mux = accumulator;
    else if (hit_pcl)
      rd_mux = prog_counter[7:0];
    else if (hit_table_ptr_low)
      rd_mux = table_ptr_low;
    else if (hit_table_ptr_high)
      rd_mux = table_ptr_high;
    else if (hit_table_data_high)
      rd_mux = table_data_high;
    else if (hit_stat)
      rd_mux = status_flags;
    else if (hit_ist)
      rd_mux = {5'h00, irq_st};
    else if (hit_ien)
      rd_mux = {5'h00, irq_en};
  end

  // program counter: bank bit sits on top of a 13-bit counter
  wire [13:0] pc_next_seq = {prog_bank_sel, prog_counter[12:0] + 13'h0001};
  wire [13:0] pc_jump = {prog_bank_sel, prog_counter[12:8], wdata_i};

  // bank register; watchdog reset in power-down keeps the bank
  // a software write beside a soft reset is dropped unless the bank is kept
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bank_select <= CBS_BANK_RST;
    else if (soft_reset_i && !wdt_reset_in_pd_i)
      bank_select <= CBS_BANK_RST;
    else if (wr_i && hit_bank)
      bank_select <= wdata_i & bank_mask;
  end

  // accumulator holds every alu result sent with alu_to_acc_i
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      accumulator <= 8'h00;
    else if (alu_fire && alu_to_acc_i)
      accumulator <= res;
    else if (wr_i && hit_acc)
      accumulator <= wdata_i;
  end

  // table pointer and fetched high byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      table_ptr_low <= 8'h00;
      table_ptr_high <= 8'h00;
      table_data_high <= 8'h00;
    end
    else
    begin
      if (wr_i && hit_table_ptr_low)
        table_ptr_low <= wdata_i;
      if (wr_i && hit_table_ptr_high)
        table_ptr_high <= wdata_i;
      if (state == CBS_TBL)
        table_data_high <= prog_data_i[15:8];
    end
  end

  // status flags; power-up clears all, including system flags
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_flags <= CBS_STATUS_RST;
    else
      status_flags <= next_status;
  end

  // sequencer and program counter
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= CBS_RUN;
      prog_counter <= 14'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == CBS_RUN && pcl_wr)
        prog_counter <= pc_jump;
      else if (state == CBS_RUN && pc_adv_i && !tbl_read_i)
        prog_counter <= pc_next_seq;
    end
  end

  // interrupt registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_st <= 3'h0;
      irq_en <= 3'h0;
    end
    else
    begin
      irq_st <= next_irq_st;
      if (wr_i && hit_ien)
        irq_en <= wdata_i[2:0];
    end
  end

  // registered outputs; status_o is loaded from next_status
  // prog_counter_o trails the counter register by one cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
      alu_result_o <= 8'h00;
      alu_result_vld_o <= 1'b0;
      prog_addr_o <= 16'h0000;
      prog_rd_o <= 1'b0;
      tbl_low_o <= 8'h00;
      tbl_low_vld_o <= 1'b0;
      dm_addr_o <= 11'h000;
      dm_bank_bad_o <= 1'b0;
      prog_counter_o <= 14'h0000;
      stall_o <= 1'b0;
      irq_o <= 1'b0;
      status_o <= 8'h00;
    end
    else
    begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      alu_result_o <= res;
      alu_result_vld_o <= alu_fire & ~alu_to_acc_i;
      prog_addr_o <= {table_ptr_high, table_ptr_low};
      prog_rd_o <= (next_state == CBS_TBL);
      tbl_low_o <= prog_data_i[7:0];
      tbl_low_vld_o <= (state == CBS_TBL);
      dm_addr_o <= {eff_bank, dm_addr_i};
      dm_bank_bad_o <= dm_bad_n;
      prog_counter_o <= prog_counter;
      stall_o <= (next_state != CBS_RUN);
      irq_o <= |(next_irq_st & irq_en);
      status_o <= next_status;
    end
  end
endmodule

// ### shared/cbs_pkg.sv
// constants and types for the core bank / status register block
package cbs_pkg;
  // variants
  localparam logic [1:0] CBS_VAR_SMALL = 2'h0;
  localparam logic [1:0] CBS_VAR_MID = 2'h1;
  localparam logic [1:0] CBS_VAR_LARGE = 2'h2;
  // register addresses on the software port
  localparam logic [7:0] CBS_ADDR_ACC = 8'h05;
  localparam logic [7:0] CBS_ADDR_PCL = 8'h06;
  localparam logic [7:0] CBS_ADDR_TABLE_PTR_LOW = 8'h07;
  localparam logic [7:0] CBS_ADDR_TABLE_DATA_HIGH = 8'h08;
  localparam logic [7:0] CBS_ADDR_STATUS = 8'h0a;
  localparam logic [7:0] CBS_ADDR_BANK = 8'h04;
  localparam logic [7:0] CBS_ADDR_TABLE_PTR_HIGH = 8'h09;
  localparam logic [7:0] CBS_ADDR_IRQ_ST = 8'h0b;
  localparam logic [7:0] CBS_ADDR_IRQ_EN = 8'h0c;
  localparam logic [7:0] CBS_ADDR_IRQ_CLR = 8'h0d;
  // special function area lies below this address
  localparam logic [7:0] CBS_SFR_TOP = 8'h80;
  // bank select fields
  localparam int CBS_PBANK_BIT = 5;
  localparam logic [7:0] CBS_BANK_MASK_SMALL = 8'h01;
  localparam logic [7:0] CBS_BANK_MASK_MID = 8'h03;
  localparam logic [7:0] CBS_BANK_MASK_LARGE = 8'h27;
  localparam logic [2:0] CBS_LAST_BANK = 3'h5;
  localparam logic [7:0] CBS_BANK_RST = 8'h00;
  // status bit positions
  localparam int CBS_C_BIT = 0;
  localparam int CBS_AC_BIT = 1;
  localparam int CBS_Z_BIT = 2;
  localparam int CBS_OV_BIT = 3;
  localparam int CBS_PDF_BIT = 4;
  localparam int CBS_TO_BIT = 5;
  localparam logic [7:0] CBS_STATUS_WMASK = 8'h0f;
  localparam logic [7:0] CBS_STATUS_RST = 8'h00;
  // interrupt status bits
  localparam int CBS_IRQ_TO = 0;
  localparam int CBS_IRQ_HALT = 1;
  localparam int CBS_IRQ_BADBANK = 2;
  // alu operations
  typedef enum logic [2:0] {
    CBS_OP_ADD, CBS_OP_SUB, CBS_OP_AND, CBS_OP_OR,
    CBS_OP_XOR, CBS_OP_RLC, CBS_OP_RRC, CBS_OP_PASS
  } cbs_op_t;
  // fetch sequencer states
  typedef enum logic [1:0] {CBS_RUN, CBS_DUMMY, CBS_TBL} cbs_state_t;
endpackage

// ### dv/cbs_core_regs_chk.sv
// assertion checker for the core bank and status register block
`timescale 1ns/1ps
module cbs_core_regs_chk
  import cbs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // software port and events
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic wdt_timeout_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic halt_instr_i,
  // alu
  input wire logic alu_go_i,
  input wire logic [2:0] alu_op_i,
  input wire logic alu_to_acc_i,
  input wire logic [7:0] alu_result_o,
  input wire logic alu_result_vld_o,
  // table, data memory, program counter
  input wire logic tbl_read_i,
  input wire logic prog_rd_o,
  input wire logic [15:0] prog_data_i,
  input wire logic [7:0] tbl_low_o,
  input wire logic tbl_low_vld_o,
  input wire logic dm_indirect_i,
  input wire logic [7:0] dm_addr_i,
  input wire logic [10:0] dm_addr_o,
  input wire logic [13:0] prog_counter_o,
  input wire logic stall_o,
  input wire logic [7:0] status_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // a plain write must not reach the system flags
  status_wr_a:
    assert property (wr_i && addr_i == CBS_ADDR_STATUS && !alu_go_i &&
      !(wdt_timeout_i | watchdog_clear_instr_i | halt_instr_i) |=>
      status_o == {2'b00, $past(status_o[5:4]), $past(wdata_i[3:0])})
    else $error("status write reached protected bits");
  halt_flags_a:
    assert property (halt_instr_i && !wdt_timeout_i &&
      !watchdog_clear_instr_i |=> status_o[5:4] == 2'b01)
    else $error("halt did not set power down and clear timeout");
  wdt_set_a:
    assert property (wdt_timeout_i |=> status_o[5])
    else $error("watchdog timeout flag not set");
  wclr_flags_a:
    assert property (watchdog_clear_instr_i && !wdt_timeout_i &&
      !halt_instr_i |=> status_o[5:4] == 2'b00)
    else $error("watchdog clear left system flags set");
  sys_hold_a:
    assert property (!(wdt_timeout_i | watchdog_clear_instr_i |
      halt_instr_i) |=> $stable(status_o[5:4]))
    else $error("system flags changed without event");
  // low counter write: one dummy cycle, then run again
  pcl_dummy_a:
    assert property (wr_i && addr_i == CBS_ADDR_PCL && !stall_o |=>
      stall_o ##1 !stall_o && prog_counter_o[7:0] == $past(wdata_i, 2))
    else $error("counter low write without single dummy cycle");
  tbl_seq_a:
    assert property (tbl_read_i && !stall_o &&
      !(wr_i && addr_i == CBS_ADDR_PCL) |=> prog_rd_o && stall_o
      ##1 tbl_low_vld_o && tbl_low_o == $past(prog_data_i[7:0]))
    else $error("table read sequence wrong");
  // direct and special-register accesses stay in bank zero
  dm_bank0_a:
    assert property ((!dm_indirect_i || dm_addr_i < CBS_SFR_TOP) |=>
      dm_addr_o == {3'h0, $past(dm_addr_i)})
    else $error("direct access left bank zero");
  zero_flag_a:
    assert property (alu_go_i && !stall_o && !alu_to_acc_i &&
      alu_op_i <= 3'd4 |=> alu_result_vld_o &&
      status_o[2] == (alu_result_o == 8'h00))
    else $error("zero flag does not match result");
endmodule

bind cbs_core_regs cbs_core_regs_chk i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .wdt_timeout_i(wdt_timeout_i),
  .watchdog_clear_instr_i(watchdog_clear_instr_i),
  .halt_instr_i(halt_instr_i), .alu_go_i(alu_go_i), .alu_op_i(alu_op_i),
  .alu_to_acc_i(alu_to_acc_i), .alu_result_o(alu_result_o),
  .alu_result_vld_o(alu_result_vld_o), .tbl_read_i(tbl_read_i),
  .prog_rd_o(prog_rd_o), .prog_data_i(prog_data_i),
  .tbl_low_o(tbl_low_o), .tbl_low_vld_o(tbl_low_vld_o),
  .dm_indirect_i(dm_indirect_i), .dm_addr_i(dm_addr_i),
  .dm_addr_o(dm_addr_o), .prog_counter_o(prog_counter_o),
  .stall_o(stall_o), .status_o(status_o)
);

// ### dv/cbs_core_regs_bench.sv
// self-checking bench for the core bank and status register block
`timescale 1ns/1ps
module cbs_core_regs_bench
  import cbs_pkg::*;
;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_q = 0, go = 0;
  logic to_acc = 0, tbl_rd = 0, indir = 0, keep = 0, srst = 0, adv = 0;
  logic [2:0] evt = 0, op = 0;
  logic [7:0] addr = 0, wdata = 0, opd = 0, dma = 0, rdata, ares, tlow, st;
  logic [15:0] pdata = 0, paddr;
  logic [13:0] pc;
  logic [10:0] dmo;
  logic vld, tvld, prd, bad, stall, irq;
  logic [7:0] q_rd[$], q_alu[$], q_tbl[$];
  logic [7:0] ta [4] = '{8'hff, 8'h80, 8'h7f, 8'h00};
  logic [7:0] tb [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
  int n_fail = 0, cmp_count = 0, cyc = 0;
  integer seed = 32'hc908;

  cbs_core_regs i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .alu_go_i(go),
    .alu_op_i(op), .alu_operand_i(opd), .alu_to_acc_i(to_acc),
    .alu_result_o(ares), .alu_result_vld_o(vld), .wdt_timeout_i(evt[0]),
    .watchdog_clear_instr_i(evt[1]), .halt_instr_i(evt[2]),
    .wdt_reset_in_pd_i(keep), .soft_reset_i(srst), .tbl_read_i(tbl_rd),
    .prog_addr_o(paddr), .prog_rd_o(prd), .prog_data_i(pdata),
    .tbl_low_o(tlow), .tbl_low_vld_o(tvld), .dm_indirect_i(indir),
    .dm_addr_i(dma), .dm_addr_o(dmo), .dm_bank_bad_o(bad),
    .pc_adv_i(adv), .prog_counter_o(pc), .stall_o(stall), .irq_o(irq),
    .status_o(st)
  );

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  task summarize;
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bus and event drivers; each strobe lasts one cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd_i <= 1;
    q_rd.push_back(e);
    @(posedge clk_i);
    rd_i <= 0;
  endtask
  task ev(input logic [2:0] e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= 0;
  endtask
  task alu(input logic [2:0] o, input logic [7:0] b, input logic t);
    @(posedge clk_i);
    op <= o;
    opd <= b;
    to_acc <= t;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
  endtask
  task sr(input logic k);
    @(posedge clk_i);
    keep <= k;
    srst <= 1;
    @(posedge clk_i);
    srst <= 0;
  endtask
  // irq is a registered level, so allow a few cycles for it to settle
  task wirq(input logic e);
    int i;
    @(posedge clk_i);
    for (i = 0; i < 4 && irq !== e; i++)
      @(posedge clk_i);
    #1;
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask

  // expected {result, ov, z, ac, c} of add (o=0) or subtract (o=1)
  function automatic logic [11:0] fl(input logic o, input logic [7:0] a,
    input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = o ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = o ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7:0], (a[7] ^ b[7] ^ ~o) & (s[7] ^ a[7]), s[7:0] == 8'h00,
      h[4] ^ o, s[8] ^ o};
  endfunction

  // result watcher: each result takes the oldest note of its kind
  always @(posedge clk_i)
    rd_q <= rd_i;
  always @(negedge clk_i)
  begin
    if (rd_q)
      chk("rdata", q_rd.pop_front(), rdata);
    if (vld)
      chk("alu_result", q_alu.pop_front(), ares);
    if (tvld)
      chk("tbl_low", q_tbl.pop_front(), tlow);
  end

  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      summarize;
    end
  end

  initial
  begin
    logic [11:0] r;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] w;
    int i;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1;
    rd(CBS_ADDR_BANK, 8'h00);
    rd(CBS_ADDR_STATUS, 8'h00);
    rd(8'h30, 8'h00);
    wr(CBS_ADDR_BANK, 8'hff);
    rd(CBS_ADDR_BANK, CBS_BANK_MASK_LARGE);
    wr(CBS_ADDR_STATUS, 8'hff);
    rd(CBS_ADDR_STATUS, 8'h0f);
    ev(3'b100);
    rd(CBS_ADDR_STATUS, 8'h1f);
    ev(3'b001);
    rd(CBS_ADDR_STATUS, 8'h3f);
    wr(CBS_ADDR_STATUS, 8'h00);
    rd(CBS_ADDR_STATUS, 8'h30);
    // interrupt: raise, mask, clear
    wr(CBS_ADDR_IRQ_CLR, 8'h07);
    wr(CBS_ADDR_IRQ_EN, 8'h01);
    ev(3'b100);
    wirq(1'b0);
    ev(3'b001);
    wirq(1'b1);
    rd(CBS_ADDR_IRQ_ST, 8'h03);
    wr(CBS_ADDR_IRQ_CLR, 8'h01);
    wirq(1'b0);
    wr(CBS_ADDR_IRQ_EN, 8'h02);
    wirq(1'b1);
    wr(CBS_ADDR_IRQ_EN, 8'h00);
    wirq(1'b0);
    wr(CBS_ADDR_IRQ_CLR, 8'h07);
    ev(3'b010);
    rd(CBS_ADDR_STATUS, 8'h00);
    // add and subtract: boundary pairs first, then random pairs
    for (i = 0; i < 10; i++)
    begin
      a = i < 4 ? ta[i] : 8'($random(seed));
      b = i < 4 ? tb[i] : 8'($random(seed));
      r = fl(i[0], a, b);
      wr(CBS_ADDR_ACC, a);
      q_alu.push_back(r[11:4]);
      alu({2'b00, i[0]}, b, 1'b0);
      rd(CBS_ADDR_STATUS, {4'h0, r[3:0]});
    end
    // logic ops and pass: result out, accumulator and c/ac/ov untouched
    wr(CBS_ADDR_ACC, 8'h5a);
    q_alu.push_back(8'hff);
    alu(3'd3, 8'ha5, 1'b0);
    q_alu.push_back(8'h00);
    alu(3'd4, 8'h5a, 1'b0);
    rd(CBS_ADDR_STATUS, {4'h0, r[3], 1'b1, r[1:0]});
    q_alu.push_back(8'h3c);
    alu(3'd7, 8'h3c, 1'b0);
    rd(CBS_ADDR_ACC, 8'h5a);
    // results pass through the accumulator
    wr(CBS_ADDR_ACC, 8'h12);
    alu(3'd0, 8'h34, 1'b1);
    rd(CBS_ADDR_ACC, 8'h46);
    alu(3'd2, 8'h00, 1'b1);
    rd(CBS_ADDR_STATUS, 8'h04);
    wr(CBS_ADDR_STATUS, 8'h00);
    wr(CBS_ADDR_ACC, 8'h81);
    alu(3'd5, 8'h81, 1'b1);
    rd(CBS_ADDR_ACC, 8'h02);
    rd(CBS_ADDR_STATUS, 8'h01);
    alu(3'd6, 8'h02, 1'b1);
    rd(CBS_ADDR_ACC, 8'h81);
    rd(CBS_ADDR_STATUS, 8'h00);
    // low counter write stalls one cycle
    wr(CBS_ADDR_PCL, 8'h5a);
    #1;
    chk("stall", 8'h01, {7'h0, stall});
    @(posedge clk_i);
    adv <= 1;
    #1;
    chk("stall", 8'h00, {7'h0, stall});
    chk("pc_low", 8'h5a, pc[7:0]);
    chk("pc_bank", 8'h01, {7'h0, pc[13]});
    @(posedge clk_i);
    adv <= 0;
    @(posedge clk_i);
    #1;
    chk("pc_next", 8'h5b, pc[7:0]);
    // table read of a random word
    w = 16'($random(seed));
    wr(CBS_ADDR_TABLE_PTR_LOW, 8'hc3);
    wr(CBS_ADDR_TABLE_PTR_HIGH, 8'h1e);
    @(posedge clk_i);
    tbl_rd <= 1;
    pdata <= w;
    q_tbl.push_back(w[7:0]);
    @(posedge clk_i);
    tbl_rd <= 0;
    #1;
    chk("paddr_hi", 8'h1e, paddr[15:8]);
    chk("paddr_lo", 8'hc3, paddr[7:0]);
    rd(CBS_ADDR_TABLE_DATA_HIGH, w[15:8]);
    // soft reset keeps the bank only for a timeout in power down
    wr(CBS_ADDR_BANK, 8'h03);
    sr(1'b1);
    rd(CBS_ADDR_BANK, 8'h03);
    sr(1'b0);
    rd(CBS_ADDR_BANK, 8'h00);
    // every bank code through an indirect access above the special area
    indir <= 1;
    for (i = 0; i < 8; i++)
    begin
      dma <= 8'($random(seed)) | 8'h80;
      wr(CBS_ADDR_BANK, 8'(i));
      @(posedge clk_i);
      #1;
      chk("dm_bank", 8'(i), {5'h0, dmo[10:8]});
      chk("dm_bad", {7'h0, i > 5}, {7'h0, bad});
    end
    indir <= 0;
    rd(CBS_ADDR_IRQ_ST, 8'h04);
    repeat (3) @(posedge clk_i);
    summarize;
  end
endmodule
